// >>> cbcr_pkg.sv
// constants shared by the clock buffer control register bank
package cbcr_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_OUT_ENABLE = 8'h00;
    localparam logic [7:0] IDX_PLL_AMP = 8'h01;
    localparam logic [7:0] IDX_SLEW = 8'h02;
    localparam logic [7:0] IDX_FREQ_SEL = 8'h03;
    localparam logic [7:0] IDX_RESERVED = 8'h04;
    localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
    localparam logic [7:0] IDX_DEV_TYPE = 8'h06;
    localparam logic [7:0] IDX_READ_COUNT = 8'h07;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_PLL_LATCH_HI = 7;
    localparam int POS_PLL_LATCH_LO = 6;
    localparam int POS_PLL_SW_SELECT = 5;
    localparam int POS_PLL_SW_HI = 4;
    localparam int POS_PLL_SW_LO = 3;
    localparam int POS_AMP_HI = 1;
    localparam int POS_AMP_LO = 0;
    localparam int POS_FREQ_EN = 5;
    localparam int POS_FREQ_HI = 4;
    localparam int POS_FREQ_LO = 3;
    localparam int POS_FB_SLEW = 0;
    localparam int COUNT_W = 5;

    // ------------------------------------------------------------------
    // reset values and fixed read values
    // ------------------------------------------------------------------
    localparam logic [5:0] RST_OUT_ENABLE = 6'h3f;
    localparam logic [5:0] RST_SLEW = 6'h3f;
    localparam logic RST_PLL_SW_SELECT = 1'b0;
    localparam logic [1:0] RST_PLL_SW = 2'h0;
    localparam logic [1:0] RST_AMP = 2'h2;
    localparam logic RST_FREQ_EN = 1'b0;
    localparam logic [1:0] RST_FREQ = 2'h0;
    localparam logic RST_FB_SLEW = 1'b1;
    localparam logic [4:0] RST_READ_COUNT = 5'h08;
    localparam logic [7:0] RESERVED_BYTE = 8'hff;
    localparam logic PLL_AMP_BIT2 = 1'b1;
    localparam logic [1:0] FREQ_BITS_2_1 = 2'h3;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    // ------------------------------------------------------------------
    // link protocol states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CBCR_IDLE = 3'b000,
        CBCR_ADDR = 3'b001,
        CBCR_INDEX = 3'b011,
        CBCR_COUNT = 3'b010,
        CBCR_WDATA = 3'b110,
        CBCR_RDATA = 3'b111,
        CBCR_HOLD = 3'b101
    } cbcr_state_t;

endpackage

// >>> cbcr_smb_front.sv
// serial bus pin synchroniser with clock edge and start/stop detection
`timescale 1ns/1ps
module cbcr_smb_front (
    input wire logic mclk_in, // system clock
    input wire logic rst_in, // async reset, active high
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // synchronised data level
    output logic scl_rise_out, // one-cycle pulse on bus clock rise
    output logic scl_fall_out, // one-cycle pulse on bus clock fall
    output logic start_out, // one-cycle pulse on start or repeated start
    output logic stop_out // one-cycle pulse on stop
);

    // ------------------------------------------------------------------
    // two-stage synchronisers, then one history stage for edges
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    // data edges while the clock stays high mark start and stop
    wire scl_high = scl_sync_r[1] & scl_prev_r;

    assign sda_out = sda_sync_r[1];
    assign scl_rise_out = scl_sync_r[1] & ~scl_prev_r;
    assign scl_fall_out = ~scl_sync_r[1] & scl_prev_r;
    assign start_out = scl_high & sda_prev_r & ~sda_sync_r[1];
    assign stop_out = scl_high & ~sda_prev_r & sda_sync_r[1];

endmodule // cbcr_smb_front

// >>> cbcr_regs.sv
// clock buffer control registers behind an indexed block serial slave
`timescale 1ns/1ps
module cbcr_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h50, // bus address of this device
    parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'ha, // arbitrary value
    parameter logic [1:0] PART_CLASS = 2'h2, // arbitrary value
    parameter logic [5:0] PART_CODE = 6'h15, // arbitrary value
    parameter int OUTPUTS = 6 // number of differential outputs
) (
    input wire logic mclk_in, // system clock, 100 MHz
    input wire logic rst_in, // power-up reset, async, active high
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // bus data drive value, always low
    output logic sda_oe_out, // high while pulling data low
    input wire logic [5:0] out_enable_pin_n_in, // per-output enable pins, active low
    input wire logic [1:0] pll_mode_strap_in, // PLL mode strap level
    output logic [5:0] diff_clock_out_en_out, // output pair running when high
    output logic [1:0] pll_mode_out, // PLL mode in effect
    output logic [1:0] amplitude_out, // output swing code
    output logic [5:0] edge_rate_out, // per-output slew, 1 fast
    output logic edge_rate_feedback_out, // feedback path slew, 1 fast
    output logic freq_sw_enable_out, // software frequency change allowed
    output logic [1:0] freq_choice_out // frequency code, valid when enabled
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (OUTPUTS != 6) begin : g_bad_outputs
        $error("register layout serves exactly six outputs");
    end

    // ------------------------------------------------------------------
    // pin front end
    // ------------------------------------------------------------------
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    cbcr_smb_front i_cbcr_smb_front (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(bus_start),
        .stop_out(bus_stop)
    );

    // enable pins and strap come from outside, so two stages each
    logic [5:0] oe_pin_meta_r;
    logic [5:0] oe_pin_n_r;
    logic [1:0] strap_meta_r;
    logic [1:0] strap_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            oe_pin_meta_r <= 6'h3f;
            oe_pin_n_r <= 6'h3f;
            strap_meta_r <= 2'h0;
            strap_r <= 2'h0;
        end else begin
            oe_pin_meta_r <= out_enable_pin_n_in;
            oe_pin_n_r <= oe_pin_meta_r;
            strap_meta_r <= pll_mode_strap_in;
            strap_r <= strap_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // strap latch: taken once, after the synchroniser has filled
    // ------------------------------------------------------------------
    logic [1:0] settle_cnt_r;
    logic [1:0] pll_latched_r;
    wire strap_take = (settle_cnt_r == cbcr_pkg::STRAP_SETTLE_CYCLES - 2'h1);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt_r <= 2'h0;
            pll_latched_r <= 2'h0;
        end else begin
            if (settle_cnt_r != cbcr_pkg::STRAP_SETTLE_CYCLES) begin
                settle_cnt_r <= settle_cnt_r + 2'h1;
            end
            if (strap_take) begin
                pll_latched_r <= strap_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------------
    logic [5:0] oe_r;
    logic pll_sel_r;
    logic [1:0] pll_sw_r;
    logic [1:0] amp_r;
    logic [5:0] slew_r;
    logic freq_en_r;
    logic [1:0] freq_r;
    logic fb_slew_r;
    logic [4:0] rd_count_r;
    logic wr_en;
    logic [7:0] idx_r;
    logic [7:0] shift_r;

    // per-output bytes skip the reserved positions 5 and 1
    wire [7:0] wb = shift_r;
    wire [5:0] wb_outs = {wb[7], wb[6], wb[4], wb[3], wb[2], wb[0]};

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            oe_r <= cbcr_pkg::RST_OUT_ENABLE;
            pll_sel_r <= cbcr_pkg::RST_PLL_SW_SELECT;
            pll_sw_r <= cbcr_pkg::RST_PLL_SW;
            amp_r <= cbcr_pkg::RST_AMP;
            slew_r <= cbcr_pkg::RST_SLEW;
            freq_en_r <= cbcr_pkg::RST_FREQ_EN;
            freq_r <= cbcr_pkg::RST_FREQ;
            fb_slew_r <= cbcr_pkg::RST_FB_SLEW;
            rd_count_r <= cbcr_pkg::RST_READ_COUNT;
        end else if (wr_en) begin
            // only writable fields are picked out; others drop
            unique case (idx_r)
                cbcr_pkg::IDX_OUT_ENABLE: begin
                    oe_r <= wb_outs;
                end
                cbcr_pkg::IDX_PLL_AMP: begin
                    pll_sel_r <= wb[cbcr_pkg::POS_PLL_SW_SELECT];
                    pll_sw_r <= {wb[cbcr_pkg::POS_PLL_SW_HI], wb[cbcr_pkg::POS_PLL_SW_LO]};
                    amp_r <= {wb[cbcr_pkg::POS_AMP_HI], wb[cbcr_pkg::POS_AMP_LO]};
                end
                cbcr_pkg::IDX_SLEW: begin
                    slew_r <= wb_outs;
                end
                cbcr_pkg::IDX_FREQ_SEL: begin
                    freq_en_r <= wb[cbcr_pkg::POS_FREQ_EN];
                    freq_r <= {wb[cbcr_pkg::POS_FREQ_HI], wb[cbcr_pkg::POS_FREQ_LO]};
                    fb_slew_r <= wb[cbcr_pkg::POS_FB_SLEW];
                end
                cbcr_pkg::IDX_READ_COUNT: begin
                    rd_count_r <= wb[cbcr_pkg::COUNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [7:0] rd_b0 = {oe_r[5], oe_r[4], 1'b0, oe_r[3], oe_r[2], oe_r[1], 1'b0, oe_r[0]};
    wire [7:0] rd_b1 = {pll_latched_r, pll_sel_r, pll_sw_r, cbcr_pkg::PLL_AMP_BIT2, amp_r};
    wire [7:0] rd_b2 = {slew_r[5], slew_r[4], 1'b0, slew_r[3], slew_r[2], slew_r[1], 1'b0,
                        slew_r[0]};
    wire [7:0] rd_b3 = {2'h0, freq_en_r, freq_r, cbcr_pkg::FREQ_BITS_2_1, fb_slew_r};
    wire [7:0] rd_b5 = {REVISION_CODE, MAKER_CODE};
    wire [7:0] rd_b6 = {PART_CLASS, PART_CODE};
    wire [7:0] rd_b7 = {3'h0, rd_count_r};
    wire [7:0] rd_byte = (idx_r == cbcr_pkg::IDX_OUT_ENABLE) ? rd_b0 :
                         (idx_r == cbcr_pkg::IDX_PLL_AMP) ? rd_b1 :
                         (idx_r == cbcr_pkg::IDX_SLEW) ? rd_b2 :
                         (idx_r == cbcr_pkg::IDX_FREQ_SEL) ? rd_b3 :
                         (idx_r == cbcr_pkg::IDX_RESERVED) ? cbcr_pkg::RESERVED_BYTE :
                         (idx_r == cbcr_pkg::IDX_REV_VENDOR) ? rd_b5 :
                         (idx_r == cbcr_pkg::IDX_DEV_TYPE) ? rd_b6 :
                         (idx_r == cbcr_pkg::IDX_READ_COUNT) ? rd_b7 :
                         cbcr_pkg::UNMAPPED_BYTE;

    // ------------------------------------------------------------------
    // block transfer engine
    // ------------------------------------------------------------------
    cbcr_pkg::cbcr_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic ack_phase_r;
    logic ack_drive_r;
    logic first_rd_r;
    logic [7:0] wr_left_r;
    logic [7:0] tx_r;
    logic sda_oe_r;

    wire byte_done = scl_fall & ~ack_phase_r & (bit_cnt_r == 4'h8);
    wire addr_match = (shift_r[7:1] == SLAVE_ADDR);
    wire in_byte = (state_r != cbcr_pkg::CBCR_IDLE) && (state_r != cbcr_pkg::CBCR_HOLD);
    wire wr_ok = (wr_left_r != 8'h00);
    // host nack ends a read
    wire host_nack = scl_rise & ack_phase_r & ~ack_drive_r & sda_s;

    assign wr_en = byte_done && (state_r == cbcr_pkg::CBCR_WDATA) && wr_ok;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= cbcr_pkg::CBCR_IDLE;
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
            first_rd_r <= 1'b0;
            wr_left_r <= 8'h00;
            idx_r <= 8'h00;
            shift_r <= 8'h00;
            tx_r <= 8'hff;
        end else if (bus_start) begin
            state_r <= cbcr_pkg::CBCR_ADDR;
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= cbcr_pkg::CBCR_IDLE;
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
        end else if (host_nack) begin
            state_r <= cbcr_pkg::CBCR_HOLD;
            ack_phase_r <= 1'b0;
        end else if (scl_rise && in_byte && !ack_phase_r) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (byte_done) begin
            ack_phase_r <= 1'b1;
            ack_drive_r <= 1'b1;
            unique case (state_r)
                cbcr_pkg::CBCR_ADDR: begin
                    if (!addr_match) begin
                        state_r <= cbcr_pkg::CBCR_HOLD;
                        ack_drive_r <= 1'b0;
                    end else if (shift_r[0]) begin
                        state_r <= cbcr_pkg::CBCR_RDATA;
                        first_rd_r <= 1'b1;
                    end else begin
                        state_r <= cbcr_pkg::CBCR_INDEX;
                    end
                end
                cbcr_pkg::CBCR_INDEX: begin
                    idx_r <= shift_r;
                    state_r <= cbcr_pkg::CBCR_COUNT;
                end
                cbcr_pkg::CBCR_COUNT: begin
                    wr_left_r <= shift_r;
                    state_r <= cbcr_pkg::CBCR_WDATA;
                end
                cbcr_pkg::CBCR_WDATA: begin
                    // bytes beyond the announced count are refused
                    if (wr_ok) begin
                        wr_left_r <= wr_left_r - 8'h01;
                        idx_r <= idx_r + 8'h01;
                    end else begin
                        state_r <= cbcr_pkg::CBCR_HOLD;
                        ack_drive_r <= 1'b0;
                    end
                end
                cbcr_pkg::CBCR_RDATA: begin
                    ack_drive_r <= 1'b0; // host owns this slot
                end
                default: begin
                    ack_phase_r <= 1'b0;
                    ack_drive_r <= 1'b0;
                end
            endcase
        end else if (scl_fall && ack_phase_r) begin
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            if (state_r == cbcr_pkg::CBCR_RDATA) begin
                first_rd_r <= 1'b0;
                if (first_rd_r) begin
                    tx_r <= {3'h0, rd_count_r};
                end else begin
                    tx_r <= rd_byte;
                    idx_r <= idx_r + 8'h01;
                end
            end
        end else if (scl_fall && state_r == cbcr_pkg::CBCR_RDATA) begin
            tx_r <= {tx_r[6:0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // data pin drive: registered so it changes after the clock fall
    // ------------------------------------------------------------------
    wire tx_low = (state_r == cbcr_pkg::CBCR_RDATA) && !ack_phase_r && !tx_r[7];
    wire sda_oe_nxt = ack_drive_r | tx_low;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= sda_oe_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_r;

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    assign diff_clock_out_en_out = oe_r & ~oe_pin_n_r;
    assign pll_mode_out = pll_sel_r ? pll_sw_r : pll_latched_r;
    assign amplitude_out = amp_r;
    assign edge_rate_out = slew_r;
    assign edge_rate_feedback_out = fb_slew_r;
    assign freq_sw_enable_out = freq_en_r;
    assign freq_choice_out = freq_en_r ? freq_r : cbcr_pkg::RST_FREQ;

endmodule // cbcr_regs

// >>> cbcr_regs_checker.sv
// concurrent checks on the ports of the clock buffer control register bank
`timescale 1ns/1ps
module cbcr_regs_checker (
    input wire logic mclk_in, // system clock
    input wire logic rst_in, // async reset, active high
    input wire logic scl_in, // bus clock pin
    input wire logic sda_oe_out, // device pulls data low
    input wire logic [5:0] out_enable_pin_n_in, // enable pins, active low
    input wire logic [1:0] pll_mode_strap_in, // mode strap
    input wire logic [5:0] diff_clock_out_en_out, // output pair running
    input wire logic [1:0] pll_mode_out, // mode in effect
    input wire logic [1:0] amplitude_out, // swing code
    input wire logic [5:0] edge_rate_out, // per-output slew
    input wire logic edge_rate_feedback_out, // feedback slew
    input wire logic freq_sw_enable_out, // sw frequency change allowed
    input wire logic [1:0] freq_choice_out // frequency code
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // a pin held high for the synchroniser depth must stop its output
    a_pin_gate_bits: assert property (
        (diff_clock_out_en_out & $past(out_enable_pin_n_in, 2) & $past(out_enable_pin_n_in, 3))
        == 6'h00) else $error("output running while its enable pin was high");
    a_freq_gated: assert property (!freq_sw_enable_out |-> freq_choice_out == 2'h0)
        else $error("frequency code active while software change disabled");
    // settings only move on a bus clock fall, never while the clock is high
    a_cfg_scl_low: assert property (
        $changed({amplitude_out, edge_rate_out, edge_rate_feedback_out, freq_sw_enable_out})
        |-> !scl_in) else $error("setting changed while bus clock high");
    a_ack_rise_low: assert property ($rose(sda_oe_out) |-> (!scl_in && sda_oe_out) [*3])
        else $error("data drive started badly");
    a_ack_fall_low: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("data drive released while bus clock high");
    a_drive_steady: assert property ($rose(scl_in) |-> $stable(sda_oe_out) [*3])
        else $error("data drive changed while bus clock high");
    a_reset_dflt: assert property ($fell(rst_in) |-> amplitude_out == 2'h2 &&
        edge_rate_out == 6'h3f && edge_rate_feedback_out && !freq_sw_enable_out &&
        !sda_oe_out && diff_clock_out_en_out == 6'h00) else $error("bad value at reset exit");
    a_strap_follow: assert property (
        $fell(rst_in) ##1 $stable(pll_mode_strap_in) [*5] |-> pll_mode_out == pll_mode_strap_in)
        else $error("mode does not follow latched strap");

    c_ack_seen: cover property ($rose(sda_oe_out));
    c_freq_on: cover property (freq_sw_enable_out && freq_choice_out == 2'h3);
    c_pin_mask: cover property (diff_clock_out_en_out == 6'h15);
endmodule // cbcr_regs_checker

bind cbcr_regs cbcr_regs_checker i_cbcr_regs_checker (.mclk_in(mclk_in), .rst_in(rst_in),
    .scl_in(scl_in), .sda_oe_out(sda_oe_out), .out_enable_pin_n_in(out_enable_pin_n_in),
    .pll_mode_strap_in(pll_mode_strap_in), .diff_clock_out_en_out(diff_clock_out_en_out),
    .pll_mode_out(pll_mode_out), .amplitude_out(amplitude_out), .edge_rate_out(edge_rate_out),
    .edge_rate_feedback_out(edge_rate_feedback_out), .freq_sw_enable_out(freq_sw_enable_out),
    .freq_choice_out(freq_choice_out));

// >>> cbcr_host.sv
// behavioural serial bus host that performs indexed block transfers
`timescale 1ns/1ps
module cbcr_host (
    input wire logic mclk_in, // system clock
    input wire logic sda_in, // resolved data line
    output logic scl_out, // bus clock level, idles high
    output logic sda_low_out // high while pulling data low
);
    localparam int PHASE = 10; // half bit in mclk, above the 8 minimum
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // ------------------------------------------------------------------
    // bus primitives
    // ------------------------------------------------------------------
    task automatic wait_phase();
        repeat (PHASE) @(posedge mclk_in);
    endtask
    // data moves a few cycles after the clock fall so it never races it
    task automatic bit_out(input logic b, output logic seen);
        repeat (3) @(posedge mclk_in);
        sda_low_out <= ~b;
        wait_phase();
        scl_out <= 1'b1;
        wait_phase();
        seen = sda_in;
        scl_out <= 1'b0;
    endtask
    task automatic start();
        repeat (3) @(posedge mclk_in);
        sda_low_out <= 1'b0;
        wait_phase();
        scl_out <= 1'b1;
        wait_phase();
        sda_low_out <= 1'b1;
        wait_phase();
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        repeat (3) @(posedge mclk_in);
        sda_low_out <= 1'b1;
        wait_phase();
        scl_out <= 1'b1;
        wait_phase();
        sda_low_out <= 1'b0;
        wait_phase();
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(d[i], s);
        bit_out(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b1, s);
            d[i] = s;
        end
        bit_out(last, s);
    endtask
endmodule // cbcr_host

// >>> cbcr_regs_tb.sv
// self-checking testbench for the clock buffer control register bank
`timescale 1ns/1ps
module cbcr_regs_tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] pin_n = 6'h00;
    logic [1:0] strap = 2'h2;
    logic scl, host_low, sda_line, sda_o, sda_oe, fb_slew, freq_en, ack;
    logic [5:0] out_en, slew;
    logic [1:0] pll_mode, amp, freq;
    logic [7:0] data_q [0:8];
    int failures = 0;
    int compares = 0;

    always #5 mclk_in = ~mclk_in;
    // pull-up: the line is low if either party pulls it
    assign sda_line = ~host_low & ~(sda_oe & ~sda_o);

    cbcr_host i_cbcr_host (.mclk_in(mclk_in), .sda_in(sda_line), .scl_out(scl),
        .sda_low_out(host_low));
    // identity codes here are arbitrary
    cbcr_regs #(.REVISION_CODE(4'h5), .MAKER_CODE(4'hc), .PART_CLASS(2'h1), .PART_CODE(6'h2b))
    i_cbcr_regs (.mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .out_enable_pin_n_in(pin_n),
        .pll_mode_strap_in(strap), .diff_clock_out_en_out(out_en), .pll_mode_out(pll_mode),
        .amplitude_out(amp), .edge_rate_out(slew), .edge_rate_feedback_out(fb_slew),
        .freq_sw_enable_out(freq_en), .freq_choice_out(freq));

    // ------------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic addr_idx(input logic [7:0] idx);
        i_cbcr_host.start();
        i_cbcr_host.send(8'ha0, ack);
        check("address ack", {7'h00, ack}, 8'h01);
        i_cbcr_host.send(idx, ack);
        check("index ack", {7'h00, ack}, 8'h01);
    endtask
    task automatic blk_wr(input logic [7:0] idx, input int n);
        addr_idx(idx);
        i_cbcr_host.send(n[7:0], ack);
        for (int i = 0; i < n; i++) begin
            i_cbcr_host.send(data_q[i], ack);
            check("data ack", {7'h00, ack}, 8'h01);
        end
        i_cbcr_host.stop();
    endtask
    task automatic blk_rd(input logic [7:0] idx, input int n);
        addr_idx(idx);
        i_cbcr_host.start();
        i_cbcr_host.send(8'ha1, ack);
        check("read address ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i <= n; i++) i_cbcr_host.recv(i == n, data_q[i]);
        i_cbcr_host.stop();
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults();
        logic [7:0] want [0:7];
        want = '{8'hdd, 8'h86, 8'hdd, 8'h07, 8'hff, 8'h5c, 8'h6b, 8'h08};
        check("enables", {2'h0, out_en}, 8'h3f);
        check("amplitude", {6'h00, amp}, 8'h02);
        blk_rd(8'h00, 8);
        check("count byte", data_q[0], 8'h08);
        for (int i = 0; i < 8; i++) check("reset byte", data_q[i + 1], want[i]);
        $display("t_defaults done");
    endtask
    // enables and slew cleared, bytes 1 and 3 all ones, reserved and read-only ones included
    task automatic t_write_all();
        logic [7:0] want [0:7];
        want = '{8'h00, 8'hbf, 8'h00, 8'h3f, 8'hff, 8'h5c, 8'h6b, 8'h03};
        data_q = '{8'h22, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'he3, 8'h00};
        blk_wr(8'h00, 8);
        check("enables", {2'h0, out_en}, 8'h00);
        check("mode", {6'h00, pll_mode}, 8'h03);
        check("amplitude", {6'h00, amp}, 8'h03);
        check("slew", {2'h0, slew}, 8'h00);
        check("frequency", {5'h00, freq_en, freq}, 8'h07);
        blk_rd(8'h00, 8);
        check("count byte", data_q[0], 8'h03);
        for (int i = 0; i < 8; i++) check("stored byte", data_q[i + 1], want[i]);
        $display("t_write_all done");
    endtask
    task automatic t_modes();
        for (int c = 0; c < 4; c++) begin
            data_q[0] = 8'h18 | 8'(c);
            blk_wr(8'h01, 1);
            check("amplitude", {6'h00, amp}, 8'(c));
            check("mode", {6'h00, pll_mode}, 8'h02);
        end
        data_q[0] = 8'h18;
        blk_wr(8'h03, 1);
        check("frequency", {5'h00, freq_en, freq}, 8'h00);
        check("feedback slew", {7'h00, fb_slew}, 8'h00);
        $display("t_modes done");
    endtask
    task automatic t_pins();
        data_q[0] = 8'hdd;
        blk_wr(8'h00, 1);
        pin_n <= 6'h2a;
        repeat (6) @(posedge mclk_in);
        check("enables", {2'h0, out_en}, 8'h15);
        pin_n <= 6'h3f;
        repeat (6) @(posedge mclk_in);
        check("enables", {2'h0, out_en}, 8'h00);
        pin_n <= 6'h00;
        $display("t_pins done");
    endtask
    task automatic t_refuse();
        i_cbcr_host.start();
        i_cbcr_host.send(8'ha2, ack);
        check("foreign address ack", {7'h00, ack}, 8'h00);
        i_cbcr_host.stop();
        blk_rd(8'h08, 1);
        check("unmapped byte", data_q[1], 8'h00);
        $display("t_refuse done");
    endtask
    // second power-up with a new strap value
    task automatic t_reset();
        strap <= 2'h1;
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        #1;
        check("mode", {6'h00, pll_mode}, 8'h01);
        check("amplitude", {6'h00, amp}, 8'h02);
        blk_rd(8'h00, 2);
        check("count byte", data_q[0], 8'h08);
        check("mode byte", data_q[2], 8'h46);
        $display("t_reset done");
    endtask

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        t_defaults();
        t_write_all();
        t_modes();
        t_pins();
        t_refuse();
        t_reset();
        close_out();
    end
    // the whole run needs about 16k cycles; allow about two and a half times that
    initial begin
        #400000;
        failures++;
        close_out();
    end
endmodule // cbcr_regs_tb
